// [inc/irq_agg_cfg.svh]
// Purpose: constants for the event aggregator
// Assumes: 100 MHz CLK
// Notes: event bit positions and pulse timing defaults
`ifndef IRQ_AGG_CFG_SVH
`define IRQ_AGG_CFG_SVH
`define EV_NUM 32
`define EV_GPIN_CHG 0
`define EV_GPIN_WAKE 5
`define EV_FD_WAKE 10
`define EV_SUB_WAKE 11
`define EV_FD_FAULT 12
`define EV_SUB_FAULT 16
`define EV_LONG_TIMER 20
`define EV_TWARN 21
`define EV_AUX_LIMIT 24
`define EV_REF_LIMIT 25
`define EV_BUCKBOOST 26
`define EV_HOST_REQ 27
`define EV_SER_ERR 28
`define EV_SER_CLK 29
`define EV_SER_REQ 30
`define EV_SER_PAR 31
`define SER_BITS 16
`define PULSE_SHORT_NS 25000
`define PULSE_LONG_NS 100000
`define CLK_PERIOD_NS 10
`define PULSE_SHORT_CYC (`PULSE_SHORT_NS / `CLK_PERIOD_NS)
`define PULSE_LONG_CYC (`PULSE_LONG_NS / `CLK_PERIOD_NS)
`endif

// [inc/irq_agg_pkg.sv]
// Purpose: types for the event aggregator
// Assumes: nothing
// Notes: pulse state enumeration
package irq_agg_pkg;
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_LOW = 2'b01,
    PS_GAP = 2'b10
  } pulse_state_t;
endpackage

// [src/irq_agg.sv]
// Purpose: latch system events and pulse the active-low interrupt pin
// Assumes: all inputs synchronous to CLK, event inputs are levels
// Notes: config is frozen when init phase ends
`timescale 1ns/1ps
`include "irq_agg_cfg.svh"
// Functional notes
// RULE1: unmasked event drives interrupt low for a pulse, then releases it
// RULE2: pulse mode and length written only during init, applied afterwards
// RULE3: per-source mask blocks the pulse for that source
// RULE4: serial frame clock count not 16 in main mode sets a flag
// RULE5: malformed access, unknown address, init write in normal mode flag
// RULE6: parity failure in main mode sets a flag
// RULE7: secured serial check failure sets a flag
// RULE8: host pulse request is recorded and pulses the interrupt
// RULE9: state change on each general input gives its own event
// RULE10: wake-up from each general input gives its own event
// RULE11: separate wake events for fd bus and sub bus
// RULE12: four fd transceiver faults are separate sources
// RULE13: four sub transceiver faults are separate sources
// RULE14: long timer match in function one gives an event
// RULE15: three regulator temperature warnings are separate sources
// RULE16: aux and ref limit timeouts only with external transistor
// RULE17: buck or boost running state is reported
// RULE18: each event latched in readable flag; masked still sets flag
module irq_agg
  import irq_agg_pkg::*;
#(
  parameter int PULSE_SHORT = `PULSE_SHORT_CYC,
  parameter int PULSE_LONG = `PULSE_LONG_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic INIT_PHASE,
  input wire logic CFG_WR,
  input wire logic CFG_PULSE_LONG,
  input wire logic CFG_IRQ_DISABLE,
  input wire logic [`EV_NUM-1:0] CFG_MASK,
  input wire logic [4:0] GPIN_LEVEL,
  input wire logic [4:0] GPIN_WAKE,
  input wire logic FD_BUS_WAKE,
  input wire logic SUB_BUS_WAKE,
  input wire logic FD_RX_STUCK_RECESSIVE,
  input wire logic FD_TX_STUCK_DOMINANT,
  input wire logic FD_BUS_STUCK_DOMINANT,
  input wire logic FD_XCVR_OVERTEMP,
  input wire logic SUB_RX_STUCK_RECESSIVE,
  input wire logic SUB_TX_STUCK_DOMINANT,
  input wire logic SUB_BUS_STUCK_DOMINANT,
  input wire logic SUB_XCVR_OVERTEMP,
  input wire logic LONG_TIMER_FUNC1,
  input wire logic LONG_TIMER_AT_RUN,
  input wire logic [2:0] TWARN,
  input wire logic EXT_PASS_FITTED,
  input wire logic AUX_LIMIT_EXPIRED,
  input wire logic REF_LIMIT_EXPIRED,
  input wire logic PREREG_BOOST,
  input wire logic HOST_IRQ_REQ,
  input wire logic SER_SECURE_FAIL,
  input wire logic SER_FRAME_END,
  input wire logic [5:0] SER_CLK_COUNT,
  input wire logic SER_PARITY_FAIL,
  input wire logic SER_MALFORMED,
  input wire logic SER_UNKNOWN_ADDR,
  input wire logic SER_INIT_REG_WR,
  input wire logic [`EV_NUM-1:0] FLAG_CLR,
  output logic [`EV_NUM-1:0] PENDING,
  output logic PREREG_BUCKBOOST_STATE,
  output logic IRQ_OUT_N
);
  logic [`EV_NUM-1:0] ev_lvl;
  logic [`EV_NUM-1:0] ev_prev_q, ev_prev_d;
  logic [`EV_NUM-1:0] rise;
  logic [`EV_NUM-1:0] flag_q, flag_d;
  logic [4:0] gpin_q, gpin_d;
  logic gpin_seen_q, gpin_seen_d;
  logic cfg_long_q, cfg_long_d;
  logic cfg_dis_q, cfg_dis_d;
  logic [`EV_NUM-1:0] mask_q, mask_d;
  logic bb_q, bb_d;
  pulse_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic pend_irq_q, pend_irq_d;
  logic irq_q, irq_d;
  logic trig;
  logic main_mode;

  assign main_mode = !INIT_PHASE;

  always_comb begin
    ev_lvl = '0;
    ev_lvl[`EV_FD_WAKE] = FD_BUS_WAKE; // [RULE11]
    ev_lvl[`EV_SUB_WAKE] = SUB_BUS_WAKE; // [RULE11]
    ev_lvl[`EV_FD_FAULT+0] = FD_RX_STUCK_RECESSIVE; // [RULE12]
    ev_lvl[`EV_FD_FAULT+1] = FD_TX_STUCK_DOMINANT; // [RULE12]
    ev_lvl[`EV_FD_FAULT+2] = FD_BUS_STUCK_DOMINANT; // [RULE12]
    ev_lvl[`EV_FD_FAULT+3] = FD_XCVR_OVERTEMP; // [RULE12]
    ev_lvl[`EV_SUB_FAULT+0] = SUB_RX_STUCK_RECESSIVE; // [RULE13]
    ev_lvl[`EV_SUB_FAULT+1] = SUB_TX_STUCK_DOMINANT; // [RULE13]
    ev_lvl[`EV_SUB_FAULT+2] = SUB_BUS_STUCK_DOMINANT; // [RULE13]
    ev_lvl[`EV_SUB_FAULT+3] = SUB_XCVR_OVERTEMP; // [RULE13]
    ev_lvl[`EV_LONG_TIMER] = LONG_TIMER_FUNC1 && LONG_TIMER_AT_RUN; // [RULE14]
    ev_lvl[`EV_TWARN+2:`EV_TWARN] = TWARN; // [RULE15]
    // timeouts mean nothing without the external pass device
    ev_lvl[`EV_AUX_LIMIT] = EXT_PASS_FITTED && AUX_LIMIT_EXPIRED; // [RULE16]
    ev_lvl[`EV_REF_LIMIT] = EXT_PASS_FITTED && REF_LIMIT_EXPIRED; // [RULE16]
    ev_lvl[`EV_HOST_REQ] = HOST_IRQ_REQ; // [RULE8]
    ev_lvl[`EV_SER_ERR] = SER_SECURE_FAIL && SER_FRAME_END; // [RULE7]
    ev_lvl[`EV_SER_CLK] = main_mode && SER_FRAME_END
        && (SER_CLK_COUNT != 6'(`SER_BITS)); // [RULE4]
    ev_lvl[`EV_SER_REQ] = SER_FRAME_END && (SER_MALFORMED
        || SER_UNKNOWN_ADDR
        || (main_mode && SER_INIT_REG_WR)); // [RULE5]
    ev_lvl[`EV_SER_PAR] = main_mode && SER_FRAME_END
        && SER_PARITY_FAIL; // [RULE6]
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gp
      assign rise[`EV_GPIN_CHG+g] = gpin_seen_q
          && (GPIN_LEVEL[g] != gpin_q[g]); // [RULE9]
      assign rise[`EV_GPIN_WAKE+g] = GPIN_WAKE[g]
          && !ev_prev_q[`EV_GPIN_WAKE+g]; // [RULE10]
    end
    for (g = `EV_FD_WAKE; g < `EV_NUM; g++) begin : lv
      if (g == `EV_BUCKBOOST) begin : bbe
        assign rise[g] = bb_q != PREREG_BOOST; // [RULE17]
      end else begin : oth
        assign rise[g] = ev_lvl[g] && !ev_prev_q[g];
      end
    end
  endgenerate

  always_comb begin
    ev_prev_d = ev_lvl;
    ev_prev_d[`EV_GPIN_WAKE+4:`EV_GPIN_WAKE] = GPIN_WAKE;
    gpin_d = GPIN_LEVEL;
    gpin_seen_d = 1'b1;
    bb_d = PREREG_BOOST; // [RULE17]
    // set beats clear on the same cycle
    flag_d = (flag_q & ~FLAG_CLR) | rise; // [RULE18]
    cfg_long_d = cfg_long_q;
    cfg_dis_d = cfg_dis_q;
    mask_d = mask_q;
    if (INIT_PHASE && CFG_WR) begin // [RULE2]
      cfg_long_d = CFG_PULSE_LONG;
      cfg_dis_d = CFG_IRQ_DISABLE;
      mask_d = CFG_MASK;
    end
  end

  // masked sources still flag but never pulse
  assign trig = |(rise & ~mask_q) && !cfg_dis_q; // [RULE3]

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    irq_d = 1'b1;
    pend_irq_d = pend_irq_q | trig;
    unique case (st_q)
      PS_IDLE: begin
        if (pend_irq_q || trig) begin // [RULE1]
          st_d = PS_LOW;
          pend_irq_d = 1'b0;
          irq_d = 1'b0;
          cnt_d = cfg_long_q ? PULSE_LONG - 1 : PULSE_SHORT - 1; // [RULE2]
        end
      end
      PS_LOW: begin
        irq_d = 1'b0;
        // zero after exactly PULSE low cycles, so lengths match the params
        if (cnt_q == '0) begin
          irq_d = 1'b1; // [RULE1]
          st_d = PS_GAP;
        end else begin
          cnt_d = cnt_q - 1;
        end
      end
      // gap then idle give two high cycles so back-to-back pulses stay distinct
      PS_GAP: st_d = PS_IDLE;
      default: st_d = PS_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ev_prev_q <= '0;
      flag_q <= '0;
      gpin_q <= '0;
      gpin_seen_q <= 1'b0;
      bb_q <= 1'b0;
      cfg_long_q <= 1'b0;
      cfg_dis_q <= 1'b0;
      mask_q <= '0;
      st_q <= PS_IDLE;
      cnt_q <= '0;
      pend_irq_q <= 1'b0;
      irq_q <= 1'b1;
    end else begin
      ev_prev_q <= ev_prev_d;
      flag_q <= flag_d;
      gpin_q <= gpin_d;
      gpin_seen_q <= gpin_seen_d;
      bb_q <= bb_d;
      cfg_long_q <= cfg_long_d;
      cfg_dis_q <= cfg_dis_d;
      mask_q <= mask_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      pend_irq_q <= pend_irq_d;
      irq_q <= irq_d;
    end
  end

  assign PENDING = flag_q;
  assign PREREG_BUCKBOOST_STATE = bb_q;
  assign IRQ_OUT_N = irq_q;

  // run of low cycles; bounds the pulse without a long delay range
  localparam int PULSE_MAX = (PULSE_LONG > PULSE_SHORT) ? PULSE_LONG
      : PULSE_SHORT;
  logic [31:0] low_run_q, low_run_d;

  always_comb begin
    low_run_d = '0;
    if (!irq_q) begin
      low_run_d = low_run_q + 32'd1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      low_run_q <= '0;
    end else begin
      low_run_q <= low_run_d;
    end
  end

  property p_pulse_start;
    @(posedge CLK) disable iff (!RESETN)
      (st_q == PS_IDLE && trig) |=> !IRQ_OUT_N;
  endproperty
  a_pulse_start: assert property (p_pulse_start) // [RULE1]
    else $error("interrupt pulse did not start");

  property p_pulse_ends;
    @(posedge CLK) disable iff (!RESETN)
      !IRQ_OUT_N |-> low_run_q < 32'(PULSE_MAX);
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) // [RULE1]
    else $error("interrupt held low");

  property p_cfg_frozen;
    @(posedge CLK) disable iff (!RESETN)
      !INIT_PHASE |=> $stable(mask_q) && $stable(cfg_long_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) // [RULE2]
    else $error("config changed outside init");

  property p_irq_disabled;
    @(posedge CLK) disable iff (!RESETN)
      (st_q == PS_IDLE && !pend_irq_q && cfg_dis_q) |=> IRQ_OUT_N;
  endproperty
  a_irq_disabled: assert property (p_irq_disabled) // [RULE2]
    else $error("pulse while interrupt output disabled");

  property p_mask_quiet;
    @(posedge CLK) disable iff (!RESETN)
      (st_q == PS_IDLE && !pend_irq_q && (rise & ~mask_q) == '0)
      |=> IRQ_OUT_N;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) // [RULE3]
    else $error("masked source pulsed");

  property p_clk_count;
    @(posedge CLK) disable iff (!RESETN)
      (main_mode && SER_FRAME_END && SER_CLK_COUNT != 6'd16)
      |=> flag_q[`EV_SER_CLK];
  endproperty
  a_clk_count: assert property (p_clk_count) // [RULE4]
    else $error("clock count error not flagged");

  property p_init_wr;
    @(posedge CLK) disable iff (!RESETN)
      (main_mode && SER_FRAME_END && SER_INIT_REG_WR)
      |=> flag_q[`EV_SER_REQ];
  endproperty
  a_init_wr: assert property (p_init_wr) // [RULE5]
    else $error("init write in normal mode not flagged");

  property p_parity;
    @(posedge CLK) disable iff (!RESETN)
      (main_mode && SER_FRAME_END && SER_PARITY_FAIL)
      |=> flag_q[`EV_SER_PAR];
  endproperty
  a_parity: assert property (p_parity) // [RULE6]
    else $error("parity error not flagged");

  property p_gpin_chg;
    @(posedge CLK) disable iff (!RESETN)
      (gpin_seen_q && GPIN_LEVEL[0] != gpin_q[0])
      |=> flag_q[`EV_GPIN_CHG];
  endproperty
  a_gpin_chg: assert property (p_gpin_chg) // [RULE9]
    else $error("input change not flagged");

  property p_flag_sticky;
    @(posedge CLK) disable iff (!RESETN)
      (flag_q[`EV_HOST_REQ] && !FLAG_CLR[`EV_HOST_REQ])
      |=> flag_q[`EV_HOST_REQ];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [RULE18]
    else $error("flag lost without clear");
endmodule

// [verification/irq_host.sv]
// Purpose: host controller model for the event aggregator
// Assumes: same clock as the aggregator, drives on rising edges
// Notes: config is qualified by cfg_wr only, so cfg_long and cfg_mask are garbled after
`timescale 1ns/1ps
module irq_host (
  input wire logic clk,
  output logic init,
  output logic cfg_wr,
  output logic cfg_long,
  output logic cfg_dis,
  output logic [31:0] cfg_mask,
  output logic req,
  output logic [31:0] flag_clr
);
  initial begin
    init = 1'b1;
    cfg_wr = 1'b0;
    cfg_long = 1'b0;
    cfg_dis = 1'b0;
    cfg_mask = 32'h0;
    req = 1'b0;
    flag_clr = 32'h0;
  end
  task automatic mode(input logic v);
    @(posedge clk);
    init <= v;
  endtask
  task automatic cfg(input logic l, input logic d, input logic [31:0] m);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_long <= l;
    cfg_dis <= d;
    cfg_mask <= m;
    @(posedge clk);
    cfg_wr <= 1'b0;
    // inverted so a design that samples late loads junk
    cfg_long <= ~l;
    cfg_mask <= ~m;
  endtask
  task automatic pulse_req();
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic clr(input logic [31:0] m);
    @(posedge clk);
    flag_clr <= m;
    @(posedge clk);
    flag_clr <= 32'h0;
  endtask
endmodule

// [verification/irq_agg_tb_top.sv]
// Purpose: self-checking bench for the event aggregator
// Assumes: short pulse 4 cycles, long pulse 8 cycles
// Notes: pulse lengths go through a queue to a monitor
`timescale 1ns/1ps
module irq_agg_tb_top;
  logic clk, resetn, fe, iw, ua, ext, bb, irq_n, init, cwr, clong, cdis;
  logic hreq, tf;
  logic [5:0] bad, ccnt;
  logic [31:0] lv, pend, msk, rs, cmask, fclr;
  int miscompares, samples_checked, ps, lo;
  int expq[$];
  // a random wrong clock count whenever the count-error bit is raised
  assign ccnt = lv[29] ? bad : 6'h10;
  irq_host host (.clk(clk), .init(init), .cfg_wr(cwr), .cfg_long(clong),
    .cfg_dis(cdis), .cfg_mask(cmask), .req(hreq), .flag_clr(fclr));
  irq_agg #(.PULSE_SHORT(4), .PULSE_LONG(8)) dut (
    .CLK(clk), .RESETN(resetn), .INIT_PHASE(init), .CFG_WR(cwr),
    .CFG_PULSE_LONG(clong), .CFG_IRQ_DISABLE(cdis), .CFG_MASK(cmask),
    .GPIN_LEVEL(lv[4:0]), .GPIN_WAKE(lv[9:5]), .FD_BUS_WAKE(lv[10]),
    .SUB_BUS_WAKE(lv[11]), .FD_RX_STUCK_RECESSIVE(lv[12]),
    .FD_TX_STUCK_DOMINANT(lv[13]), .FD_BUS_STUCK_DOMINANT(lv[14]),
    .FD_XCVR_OVERTEMP(lv[15]), .SUB_RX_STUCK_RECESSIVE(lv[16]),
    .SUB_TX_STUCK_DOMINANT(lv[17]), .SUB_BUS_STUCK_DOMINANT(lv[18]),
    .SUB_XCVR_OVERTEMP(lv[19]), .LONG_TIMER_FUNC1(tf),
    .LONG_TIMER_AT_RUN(lv[20]), .TWARN(lv[23:21]), .EXT_PASS_FITTED(ext),
    .AUX_LIMIT_EXPIRED(lv[24]), .REF_LIMIT_EXPIRED(lv[25]),
    .PREREG_BOOST(lv[26]), .HOST_IRQ_REQ(hreq), .SER_SECURE_FAIL(lv[28]),
    .SER_FRAME_END(fe), .SER_CLK_COUNT(ccnt),
    .SER_PARITY_FAIL(lv[31]), .SER_MALFORMED(lv[30]),
    .SER_UNKNOWN_ADDR(ua), .SER_INIT_REG_WR(iw), .FLAG_CLR(fclr),
    .PENDING(pend), .PREREG_BUCKBOOST_STATE(bb), .IRQ_OUT_N(irq_n));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // level stays put after the call; frame end only pulses
  task hit(input int k, input logic v);
    @(posedge clk);
    lv <= v ? (lv | (32'h1 << k)) : (lv & ~(32'h1 << k));
    fe <= (k > 27);
    if (!msk[k] && (v || k < 5 || k == 26) && (k != 20 || tf))
      expq.push_back(ps);
    @(posedge clk);
    fe <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task frame(input logic [31:0] l, input logic [1:0] wu, logic [31:0] e);
    @(posedge clk);
    lv <= l;
    {iw, ua} <= wu;
    fe <= 1'b1;
    if (e != 32'h0) expq.push_back(ps);
    @(posedge clk);
    lv <= 32'h0;
    {iw, ua} <= 2'b00;
    fe <= 1'b0;
    repeat (14) @(posedge clk);
    chk("pending", pend, e);
    host.clr(32'hffff_ffff);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulse length measured in edges seen low
  always @(posedge clk) begin
    if (!resetn) lo = 0;
    else if (irq_n === 1'b0) lo++;
    else if (irq_n !== 1'b1) chk("irq level", {31'h0, irq_n}, 32'h1);
    else if (lo != 0) begin
      chk("pulse", lo, expq.size() ? expq.pop_front() : 0);
      lo = 0;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    {resetn, fe, iw, ua, ext, lv} = 37'h01_0000_0000;
    tf = 1'b1;
    ps = 4;
    rs = 32'h8a43;
    repeat (40) rs = lfsr(rs);
    msk = rs & ~32'h0800_0000;
    bad = (rs[21:16] == 6'h10) ? 6'h11 : rs[21:16];
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("pending", pend, 32'h0);
    host.cfg(1'b0, 1'b0, msk);
    host.mode(1'b0);
    for (int k = 0; k < 32; k++) begin
      if (k != 27) begin
        hit(k, 1'b1);
        chk("pending", pend, 32'h1 << k);
        if (k == 26) chk("mode", {31'h0, bb}, 32'h1);
        host.clr(32'hffff_ffff);
        hit(k, 1'b0);
        chk("pending", pend, (k < 5 || k == 26) ? 32'h1 << k : 0);
        if (k == 26) chk("mode", {31'h0, bb}, 32'h0);
        host.clr(32'hffff_ffff);
      end
    end
    tf <= 1'b0;
    hit(20, 1'b1);
    chk("pending", pend, 32'h0);
    hit(20, 1'b0);
    tf <= 1'b1;
    $display("test event sources done");
    host.cfg(1'b1, 1'b0, 32'h0);
    expq.push_back(ps);
    host.pulse_req();
    repeat (12) @(posedge clk);
    chk("pending", pend, 32'h0800_0000);
    host.clr(32'hffff_ffff);
    $display("test late config done");
    host.mode(1'b1);
    resetn <= 1'b0;
    ext <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    ps = 8;
    frame(32'ha100_0000, 2'b10, 32'h0);
    host.cfg(1'b1, 1'b1, 32'h0);
    host.mode(1'b0);
    host.pulse_req();
    repeat (14) @(posedge clk);
    chk("pending", pend, 32'h0800_0000);
    host.clr(32'hffff_ffff);
    host.mode(1'b1);
    host.cfg(1'b1, 1'b0, 32'h0);
    host.mode(1'b0);
    frame(32'h0, 2'b10, 32'h4000_0000);
    frame(32'h0, 2'b01, 32'h4000_0000);
    expq.push_back(ps);
    host.pulse_req();
    repeat (14) @(posedge clk);
    chk("pending", pend, 32'h0800_0000);
    chk("left", expq.size(), 32'h0);
    $display("test init phase done");
    report_and_stop();
  end
endmodule
